// ==== rtl/dvm_display.sv ====
// Purpose: Holds the display store and multiplexes it onto the digit bus.
// Assumes: Store loads arrive as one-cycle pulses from the sequencer.
// Notes: bcd_mode selects the four-line complement bus on seg_out[3:0].
module dvm_display
  import dvm_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic clk_en, // freezes all state when low
  input wire logic bcd_mode, // 1 selects BCD bus
  input wire logic store_load, // load reading into store
  input wire reading_t store_data, // reading to load
  input wire logic store_neg, // captured sign, 1 means negative
  input wire logic over_flag, // overrange is set
  dvm_if.dst link, // counter state and flash
  output logic [3:0] strobe, // one-hot digit strobes
  output logic [6:0] seg_out // segment or BCD lines
);

  // ----------------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------------
  function automatic logic [6:0] seg7(input logic [3:0] d);
    case (d)
      4'h0: seg7 = 7'h3F;
      4'h1: seg7 = 7'h06;
      4'h2: seg7 = 7'h5B;
      4'h3: seg7 = 7'h4F;
      4'h4: seg7 = 7'h66;
      4'h5: seg7 = 7'h6D;
      4'h6: seg7 = 7'h7D;
      4'h7: seg7 = 7'h07;
      4'h8: seg7 = 7'h7F;
      4'h9: seg7 = 7'h6F;
      default: seg7 = 7'h00;
    endcase
  endfunction

  function automatic logic [6:0] bcdc(input logic [3:0] d);
    bcdc = {3'h0, ~d};
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reading_t store_ff, nxt_store;
  logic sign_ff, nxt_sign;
  logic [1:0] sel_ff, nxt_sel;
  logic [0:0] sub_ff, nxt_sub;
  logic [3:0] strobe_ff, nxt_strobe;
  logic [6:0] seg_ff, nxt_seg;
  reading_t shown;
  logic [3:0] dig;
  logic sign_shown;

  always_comb begin
    nxt_store = store_ff;
    nxt_sign = sign_ff;
    if (store_load) begin
      nxt_store = store_data;
      nxt_sign = store_neg;
    end
    nxt_sub = sub_ff + 1'h1;
    nxt_sel = sel_ff;
    if (sub_ff == STROBE_LAST) begin
      nxt_sel = sel_ff + 2'h1;
    end
    nxt_strobe = 4'h1 << nxt_sel;
    // Overrange blanks the main digits to zero.
    shown = over_flag ? '0 : store_ff;
    // No reading is stored on overrange, so show the fresh polarity instead.
    sign_shown = over_flag ? store_neg : sign_ff;
    case (nxt_sel)
      2'h1: dig = shown.hun;
      2'h2: dig = shown.ten;
      2'h3: dig = shown.uni;
      default: dig = 4'h0;
    endcase
    if (nxt_sel == 2'h0) begin
      if (bcd_mode) begin
        nxt_seg = {3'h0, ~shown.lead, over_flag & link.flash, sign_shown,
                   shown.lead};
      end else begin
        nxt_seg = {sign_shown, 2'h0, over_flag & link.flash,
                   shown.lead, shown.lead, over_flag & link.flash};
      end
    end else begin
      nxt_seg = bcd_mode ? bcdc(dig) : seg7(dig);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      store_ff <= '0;
      sign_ff <= 1'b0;
      sel_ff <= STROBE_RST;
      sub_ff <= 1'h0;
      strobe_ff <= 4'h1;
      seg_ff <= SEG_RST;
    end else if (clk_en) begin
      store_ff <= nxt_store;
      sign_ff <= nxt_sign;
      sel_ff <= nxt_sel;
      sub_ff <= nxt_sub;
      strobe_ff <= nxt_strobe;
      seg_ff <= nxt_seg;
    end
  end

  assign strobe = strobe_ff;
  assign seg_out = seg_ff;

endmodule

// ==== rtl/dvm_if.sv ====
// Purpose: Carries the measurement counter state to the display module.
// Assumes: Same clock domain on both sides.
// Notes: The sequencer drives, the display multiplexer listens.
interface dvm_if;
  import dvm_pkg::*;
  reading_t count;
  logic count_wrap;
  logic flash;

  modport src (output count, output count_wrap, output flash);
  modport dst (input count, input count_wrap, input flash);
endinterface

// ==== rtl/dvm_pkg.sv ====
// Purpose: Shared constants and types for the dual-slope voltmeter sequencer.
// Assumes: One 25 MHz clock, synchronous active-high reset.
// Notes: Segment vectors are ordered {g,f,e,d,c,b,a}.
package dvm_pkg;

  // ----------------------------------------------------------------------
  // Counter and timing constants
  // ----------------------------------------------------------------------
  localparam logic [3:0] DEC_MAX = 4'h9;
  localparam logic [3:0] DEC_ZERO = 4'h0;
  localparam int STROBE_CYCLES = 2;
  localparam logic [0:0] STROBE_LAST = 1'h1;
  localparam int CHOP_DIV = 100;
  localparam logic [5:0] CHOP_HALF = 6'h31;
  localparam logic [1:0] STROBE_RST = 2'h0;
  localparam logic [6:0] SEG_RST = 7'h00;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_SIGNAL,
    PH_REF
  } phase_t;

  typedef struct packed {
    logic lead;
    logic [3:0] hun;
    logic [3:0] ten;
    logic [3:0] uni;
  } reading_t;

endpackage

// ==== rtl/dvm_sequencer.sv ====
// Purpose: Dual-slope voltmeter sequencer: counter, switches, display.
// Assumes: Comparator input is asynchronous and is synchronised here.
// Notes: Outputs come from flip-flops; no software registers.
// Overview of operation
// - In reference phase, comparator 0 selects positive, 1 negative reference.
// - Signal switch is high exactly while the signal is integrated.
// - Each of four strobes is high two clocks in turn, one at a time.
// - Strobe one lead/sign/overrange; two hundreds; three tens; four units.
// - Seven-segment strobe one: one on B,C; minus on G; overrange flashes A,D.
// - Digit strobes use the standard active-high seven-segment patterns.
// - BCD variant outputs complemented digits, A is bit 0 to D bit 3.
// - BCD strobe one: lead on A, its complement on D, sign B, overrange C.
// - BCD variant gives a chopper square wave at clock over one hundred.
// - After reset, signal and both reference switches are low.
// - Counter runs always; wrap toggles phase flop, first toggle raises signal.
// - After 2000 more clocks, capture polarity and drop the signal switch.
// - Then energise the reference switch opposite to the captured polarity.
// - Comparator change ends reference phase and loads counter and sign.
// - No change within a whole counter cycle sets overrange until next wrap.
// - During overrange the three main digits show 000 and the flag flashes.
// - Store is gated a decade per strobe onto seven or four lines.
module dvm_sequencer
  import dvm_pkg::*;
(
  input wire logic mclk, // 25 MHz system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic clk_en, // freezes all state when low
  input wire logic cmp_in, // integrator comparator, 1 positive
  input wire logic bcd_mode, // 1 selects BCD variant outputs
  output logic sig_sw, // signal switch
  output logic ref_pos_sw, // positive reference switch
  output logic ref_neg_sw, // negative reference switch
  output logic over_out, // overrange flag
  output logic chopper, // clock divided by 100, BCD variant
  output logic strobe_lead_sign, // digit strobe one
  output logic strobe_hundreds, // digit strobe two
  output logic strobe_tens, // digit strobe three
  output logic strobe_units, // digit strobe four
  output logic [6:0] seg_out // segments {g..a} or BCD on [3:0]
);

  // ----------------------------------------------------------------------
  // Comparator synchroniser
  // ----------------------------------------------------------------------
  logic cmp_s1_ff, cmp_s2_ff, cmp_prev_ff;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
    end else if (clk_en) begin
      cmp_s1_ff <= cmp_in;
      cmp_s2_ff <= cmp_s1_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Measurement counter and phase control
  // ----------------------------------------------------------------------
  dvm_if link ();

  reading_t cnt_ff, nxt_cnt;
  logic wrap;
  logic half_ff, nxt_half;
  phase_t ph_ff, nxt_ph;
  logic neg_ff, nxt_neg;
  logic sig_ff, nxt_sig;
  logic rpos_ff, nxt_rpos;
  logic rneg_ff, nxt_rneg;
  logic over_ff, nxt_over;
  logic flash_ff, nxt_flash;
  logic [5:0] chop_cnt_ff, nxt_chop_cnt;
  logic chop_ff, nxt_chop;
  logic load;
  logic nxt_prev;

  function automatic logic [3:0] dec_inc(input logic [3:0] d);
    dec_inc = (d == DEC_MAX) ? DEC_ZERO : d + 4'h1;
  endfunction

  always_comb begin
    // Decades ripple like a BCD counter; thousands is one bit.
    nxt_cnt = cnt_ff;
    nxt_cnt.uni = dec_inc(cnt_ff.uni);
    if (cnt_ff.uni == DEC_MAX) begin
      nxt_cnt.ten = dec_inc(cnt_ff.ten);
      if (cnt_ff.ten == DEC_MAX) begin
        nxt_cnt.hun = dec_inc(cnt_ff.hun);
        if (cnt_ff.hun == DEC_MAX) begin
          nxt_cnt.lead = ~cnt_ff.lead;
        end
      end
    end
    wrap = cnt_ff.lead && cnt_ff.hun == DEC_MAX && cnt_ff.ten == DEC_MAX
           && cnt_ff.uni == DEC_MAX;
    nxt_half = wrap ? ~half_ff : half_ff;
    // Lit for the first half of each counter cycle, so an overrange,
    // which lasts one whole cycle, always blinks once.
    nxt_flash = ~nxt_cnt.lead;
    nxt_ph = ph_ff;
    nxt_neg = neg_ff;
    nxt_sig = sig_ff;
    nxt_rpos = rpos_ff;
    nxt_rneg = rneg_ff;
    nxt_over = over_ff;
    nxt_prev = cmp_s2_ff;
    load = 1'b0;
    if (wrap) begin
      nxt_over = 1'b0;
    end
    case (ph_ff)
      PH_IDLE: begin
        if (wrap) begin
          nxt_ph = PH_SIGNAL;
          nxt_sig = 1'b1;
        end
      end
      PH_SIGNAL: begin
        if (wrap) begin
          // Sign is taken as the integrator ends its run-up.
          nxt_neg = ~cmp_s2_ff;
          nxt_sig = 1'b0;
          nxt_ph = PH_REF;
          nxt_rpos = ~cmp_s2_ff;
          nxt_rneg = cmp_s2_ff;
        end
      end
      PH_REF: begin
        if (cmp_s2_ff != cmp_prev_ff) begin
          nxt_rpos = 1'b0;
          nxt_rneg = 1'b0;
          load = 1'b1;
          nxt_ph = PH_IDLE;
        end else if (wrap) begin
          // A full cycle with no crossing; start over after a fresh cycle.
          nxt_over = 1'b1;
          nxt_rpos = 1'b0;
          nxt_rneg = 1'b0;
          nxt_ph = PH_IDLE;
        end
      end
      default: nxt_ph = PH_IDLE;
    endcase
    nxt_chop_cnt = (chop_cnt_ff == CHOP_HALF) ? 6'h00 : chop_cnt_ff + 6'h01;
    nxt_chop = (chop_cnt_ff == CHOP_HALF) ? ~chop_ff : chop_ff;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_ff <= '0;
      half_ff <= 1'b0;
      ph_ff <= PH_IDLE;
      neg_ff <= 1'b0;
      sig_ff <= 1'b0;
      rpos_ff <= 1'b0;
      rneg_ff <= 1'b0;
      over_ff <= 1'b0;
      flash_ff <= 1'b0;
      chop_cnt_ff <= 6'h00;
      chop_ff <= 1'b0;
      cmp_prev_ff <= 1'b0;
    end else if (clk_en) begin
      cnt_ff <= nxt_cnt;
      half_ff <= nxt_half;
      ph_ff <= nxt_ph;
      neg_ff <= nxt_neg;
      sig_ff <= nxt_sig;
      rpos_ff <= nxt_rpos;
      rneg_ff <= nxt_rneg;
      over_ff <= nxt_over;
      flash_ff <= nxt_flash;
      chop_cnt_ff <= nxt_chop_cnt;
      chop_ff <= nxt_chop;
      cmp_prev_ff <= nxt_prev;
    end
  end

  assign link.count = cnt_ff;
  assign link.count_wrap = wrap;
  assign link.flash = flash_ff;

  // ----------------------------------------------------------------------
  // Display store and multiplexer
  // ----------------------------------------------------------------------
  logic [3:0] strobe;

  dvm_display u_disp (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .bcd_mode(bcd_mode),
    .store_load(load),
    .store_data(cnt_ff),
    .store_neg(neg_ff),
    .over_flag(over_ff),
    .link(link),
    .strobe(strobe),
    .seg_out(seg_out)
  );

  assign sig_sw = sig_ff;
  assign ref_pos_sw = rpos_ff;
  assign ref_neg_sw = rneg_ff;
  assign over_out = over_ff;
  assign chopper = chop_ff;
  assign strobe_lead_sign = strobe[0];
  assign strobe_hundreds = strobe[1];
  assign strobe_tens = strobe[2];
  assign strobe_units = strobe[3];

endmodule

// ==== tb/dvm_integrator.sv ====
// Purpose: Behavioural integrator and comparator facing the sequencer.
// Assumes: Input and reference are expressed in counts per clock.
// Notes: A reference step of 2000 makes the reading track vin.
module dvm_integrator (
  input wire logic mclk, // clock
  input wire logic az, // zeroes the integrator
  input wire logic sig_sw, // signal switch
  input wire logic ref_pos_sw, // positive reference
  input wire logic ref_neg_sw, // negative reference
  input wire logic signed [31:0] vin, // applied signal
  output logic cmp_in // comparator
);
  timeunit 1ns;
  timeprecision 1ps;
  int acc = 0;
  always @(posedge mclk) begin
    if (az)
      acc <= 0;
    else if (sig_sw)
      acc <= acc + vin;
    else if (ref_pos_sw)
      acc <= acc + 2000;
    else if (ref_neg_sw)
      acc <= acc - 2000;
  end
  // Zero reads as positive, so a zero input still gives one ramp back.
  assign cmp_in = (acc >= 0);
endmodule

// ==== tb/dvm_sequencer_monitor.sv ====
// Purpose: Port checker for the voltmeter sequencer.
// Assumes: One clock; clk_en is held high while checking.
// Notes: Helper counters time the signal phase and the chopper.
module dvm_sequencer_monitor (
  input wire logic mclk, // clock
  input wire logic sys_rst, // reset
  input wire logic cmp_in, // comparator
  input wire logic sig_sw, // signal switch
  input wire logic ref_pos_sw, // positive reference
  input wire logic ref_neg_sw, // negative reference
  input wire logic over_out, // overrange
  input wire logic chopper, // divided clock
  input wire logic strobe_lead_sign, // strobe one
  input wire logic strobe_hundreds, // strobe two
  input wire logic strobe_tens, // strobe three
  input wire logic strobe_units // strobe four
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [11:0] sig_cnt_ff;
  logic [6:0] chop_cnt_ff;
  logic chop_q_ff;
  logic chop_seen_ff;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sig_cnt_ff <= 12'h000;
      chop_cnt_ff <= 7'h00;
      chop_q_ff <= 1'b0;
      chop_seen_ff <= 1'b0;
    end else begin
      sig_cnt_ff <= sig_sw ? sig_cnt_ff + 12'h001 : 12'h000;
      chop_cnt_ff <= (chopper != chop_q_ff) ? 7'h01 : chop_cnt_ff + 7'h01;
      chop_q_ff <= chopper;
      chop_seen_ff <= chop_seen_ff | (chopper != chop_q_ff);
    end
  end
  property p_onehot;
    $onehot({strobe_lead_sign, strobe_hundreds, strobe_tens, strobe_units});
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("strobes not one-hot");
  property p_order;
    ($fell(strobe_lead_sign) |-> strobe_hundreds) and
    ($fell(strobe_hundreds) |-> strobe_tens) and
    ($fell(strobe_tens) |-> strobe_units) and
    ($fell(strobe_units) |-> strobe_lead_sign);
  endproperty
  a_order: assert property (p_order)
    else $error("strobe order broken");
  property p_len;
    $rose(strobe_tens) |=> strobe_tens ##1 !strobe_tens;
  endproperty
  a_len: assert property (p_len)
    else $error("strobe not two clocks");
  property p_sig_len;
    $fell(sig_sw) |-> sig_cnt_ff == 12'h7D0;
  endproperty
  a_sig_len: assert property (p_sig_len)
    else $error("signal phase length wrong");
  property p_ref_pol;
    ($rose(ref_pos_sw) |-> !$past(cmp_in, 3)) and
    ($rose(ref_neg_sw) |-> $past(cmp_in, 3));
  endproperty
  a_ref_pol: assert property (p_ref_pol)
    else $error("wrong reference selected");
  property p_over_fall;
    $fell(over_out) |-> sig_sw;
  endproperty
  a_over_fall: assert property (p_over_fall)
    else $error("overrange cleared off the wrap");
  property p_chop;
    chop_seen_ff && chopper != chop_q_ff |-> chop_cnt_ff == 7'h32;
  endproperty
  a_chop: assert property (p_chop)
    else $error("chopper half period wrong");
  property p_rst;
    disable iff (1'b0) sys_rst |=> !sig_sw && !ref_pos_sw && !ref_neg_sw;
  endproperty
  a_rst: assert property (p_rst)
    else $error("switch active after reset");
  c_over: cover property ($rose(over_out));
  c_pos: cover property ($rose(ref_pos_sw));
  c_neg: cover property ($rose(ref_neg_sw));
endmodule
bind dvm_sequencer dvm_sequencer_monitor mon_u (.mclk, .sys_rst, .cmp_in,
  .sig_sw, .ref_pos_sw, .ref_neg_sw, .over_out, .chopper, .strobe_lead_sign,
  .strobe_hundreds, .strobe_tens, .strobe_units);

// ==== tb/tb_dvm_sequencer.sv ====
// Purpose: Self-checking bench for the voltmeter sequencer.
// Assumes: clk_en held high; the integrator model closes the loop.
// Notes: Loop latency lets a reading exceed the input by a few counts.
module tb_dvm_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] SEGS [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66,
    7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
  localparam int CORNER [7] = '{0, -1, 999, -1500, 1985, 2500, -2600};
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic bcd_mode = 1'b0;
  logic signed [31:0] vin = 32'sh0;
  logic cmp_in, sig_sw, ref_pos_sw, ref_neg_sw, over_out, chopper, ref_any;
  logic [3:0] stb;
  logic [6:0] seg_out;
  int seed = 44;
  int err_count = 0;
  int comparisons = 0;
  assign ref_any = ref_pos_sw | ref_neg_sw;
  always #20 mclk = ~mclk;
  dvm_sequencer dut_u (.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1),
    .cmp_in(cmp_in), .bcd_mode(bcd_mode), .sig_sw(sig_sw),
    .ref_pos_sw(ref_pos_sw), .ref_neg_sw(ref_neg_sw), .over_out(over_out),
    .chopper(chopper), .strobe_lead_sign(stb[3]), .strobe_hundreds(stb[2]),
    .strobe_tens(stb[1]), .strobe_units(stb[0]), .seg_out(seg_out));
  dvm_integrator ana_u (.mclk(mclk), .az(sys_rst), .sig_sw(sig_sw),
    .ref_pos_sw(ref_pos_sw), .ref_neg_sw(ref_neg_sw), .vin(vin),
    .cmp_in(cmp_in));
  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [6:0] enc(input int d, input logic bm);
    return bm ? {3'h0, ~d[3:0]} : SEGS[d];
  endfunction
  function automatic int dec(input logic [6:0] s, input logic bm);
    for (int d = 0; d < 10; d++)
      if (s === enc(d, bm)) return d;
    return 99;
  endfunction
  task automatic wait_lvl(ref logic s, input logic lvl);
    int n;
    n = 0;
    while (s !== lvl && n < 6000) begin
      @(negedge mclk);
      n++;
    end
    chk({6'h0, s}, {6'h0, lvl});
  endtask
  task automatic measure(input int v, input logic bm);
    logic [6:0] s [4];
    logic neg, lead, over;
    int mag, rd;
    @(posedge mclk);
    vin <= v;
    bcd_mode <= bm;
    neg = (v < 0);
    mag = neg ? -v : v;
    over = (mag >= 2000);
    wait_lvl(sig_sw, 1'b1);
    wait_lvl(sig_sw, 1'b0);
    chk({5'h0, ref_neg_sw, ref_pos_sw}, {5'h0, !neg, neg});
    wait_lvl(ref_any, 1'b0);
    repeat (12) @(negedge mclk);
    for (int k = 0; k < 8; k++) begin
      @(negedge mclk);
      for (int j = 0; j < 4; j++)
        if (stb[3 - j]) s[j] = seg_out;
    end
    chk({6'h0, over_out}, {6'h0, over});
    lead = bm ? s[0][0] : s[0][1];
    // Overrange is read early in its cycle, while the flash phase is lit.
    if (bm)
      chk(s[0], {3'h0, ~lead, over, neg, lead});
    else
      chk(s[0], {neg, 2'h0, over, lead, lead, over});
    rd = (lead === 1'b1 ? 1000 : 0) + dec(s[1], bm) * 100;
    rd = rd + dec(s[2], bm) * 10 + dec(s[3], bm);
    if (over)
      chk({6'h0, rd == 0}, 7'h01);
    else
      chk({6'h0, rd >= mag - 4 && rd <= mag + 12}, 7'h01);
  endtask
  task automatic do_reset();
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (7) @(posedge mclk);
    @(negedge mclk);
    chk({4'h0, sig_sw, ref_any, over_out}, 7'h00);
    @(posedge mclk);
    sys_rst <= 1'b0;
  endtask
  task automatic finish_test();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    int v;
    do_reset();
    foreach (CORNER[i])
      measure(CORNER[i], i[0]);
    wait_lvl(sig_sw, 1'b1);
    do_reset();
    for (int k = 0; k < 6; k++) begin
      v = $random(seed) % 1961;
      // Tiny inputs could be swamped by the previous ramp's overshoot.
      if (v > -20 && v < 20)
        v = 20;
      measure(v, 1'($random(seed)));
    end
    finish_test();
  end
  initial begin
    #4_000_000;
    err_count++;
    finish_test();
  end
endmodule
